// ---- rtl/cvs_setpoint_regs.sv ----
// charge voltage / current setpoints, low-battery clamps, status bytes
// assumes a byte register port where each strobe lasts one cycle and
// all analog comparator results arrive already synchronous to clk
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - voltage setpoint spans 1.024 V to 23 V in 8 mV steps.
// - writes outside the voltage range are dropped, old setpoint kept.
// - after reset voltage loads 4200 mV per configured cell, one to five.
// - with power good, a nonzero current write starts charge, default voltage if unset.
// - writing zero voltage keeps voltage and clears current setpoint.
// - 12-bit code, high byte bits 6..0, low byte bits 7..3.
// - high byte bit 7 set makes the whole write invalid.
// - low byte bits 2..0 are ignored and read as zero.
// - two to four cells clamp current to 384 mA below minimum system.
// - one cell clamps current to 384 mA below 3 V.
// - one cell between 3 V and 3.6 V clamps current to 2 A.
// - all clamps lift above the minimum system voltage.
// - status word at 21h/20h resets to zero; high byte state flags.
// - low byte holds fault flags; only bits 4 and 3 host-writable.
// - input present flag follows the input voltage window.
// - current clears on zero voltage, removal, register reset, watchdog.
module cvs_setpoint_regs
   import cvs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // byte register port
   input wire cvs_req_s req,
   output logic [7:0] reg_rdata,
   // configuration and system events
   input wire logic [2:0] cell_count_select_pin,
   input wire logic battery_present,
   input wire logic vbus_in_window,
   input wire logic charger_power_good,
   input wire logic reg_reset_req,
   input wire logic watchdog_event,
   // battery voltage comparators
   input wire logic batt_below_min_sys,
   input wire logic batt_below_3v,
   // converter status and fault events
   input wire cvs_status_s status_in,
   input wire cvs_fault_s fault_evt,
   // setpoints to the regulation loops and the state byte
   output logic [11:0] charge_voltage_setpoint,
   output logic [6:0] charge_current_setpoint,
   output logic [15:0] charge_current_limit_ma,
   output logic charge_enable,
   output logic [7:0] charger_state_register
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      cvs_state_e state;
      logic [11:0] volt;
      logic [7:0] volt_lo_stage;
      logic [6:0] cur;
      logic [7:0] cur_lo_stage;
      logic charging;
      logic [15:0] limit_ma;
      logic [7:0] state_flags;
      logic [7:0] rdata;
   } cvs_regs_s;

   cvs_regs_s st_reg;
   cvs_regs_s st_next;

   logic [7:0] fault_flags;
   logic [11:0] wr_volt_code;
   logic [6:0] wr_cur_code;
   logic [11:0] cell_default;
   logic volt_hi_wr;
   logic cur_hi_wr;
   logic volt_zero;
   logic volt_ok;
   logic cur_ok;
   logic cur_clear;
   logic [15:0] base_ma;
   logic [15:0] clamp_ma;
   logic clamp_on;
   logic fault_wr;

   // ****************************************************************
   // fault flags
   // ****************************************************************
   // only the system over/undervoltage bits can be cleared by the host
   assign fault_wr = req.wr && (req.addr == CVS_OFS_FAULT);

   for (genvar i = 0; i < 8; i++) begin : g_fault
      cvs_flag_cell #(
         .WRITABLE(CVS_FAULT_WR_MASK[i])
      ) u_cell (
         .clk(clk),
         .rst_n(rst_n),
         .event_in(fault_evt[i]),
         .wr_en(fault_wr),
         .wr_val(req.wdata[i]),
         .flag(fault_flags[i])
      );
   end

   // ****************************************************************
   // write decode
   // ****************************************************************
   // the high byte commits the pair, so a half-written value never acts
   assign volt_hi_wr = req.wr && (req.addr == CVS_OFS_VOLT_HI);
   assign cur_hi_wr = req.wr && (req.addr == CVS_OFS_CUR_HI);
   // assemble the 12-bit code; low bits 2..0 are dropped here
   assign wr_volt_code = {req.wdata[6:0],
      st_reg.volt_lo_stage[7:CVS_VOLT_LO_LSB]};
   assign wr_cur_code = {req.wdata[4:0],
      st_reg.cur_lo_stage[7:CVS_CUR_LO_LSB]};
   // bit 7 of the high byte set is an invalid write
   assign volt_zero = (wr_volt_code == 12'h000) &&
      !req.wdata[CVS_VOLT_HI_RSVD_BIT];
   assign volt_ok = !req.wdata[CVS_VOLT_HI_RSVD_BIT] &&
      (wr_volt_code >= CVS_CODE_MIN) &&
      (wr_volt_code <= CVS_CODE_MAX);
   assign cur_ok = (req.wdata & CVS_CUR_HI_RSVD_MASK) == 8'h00;

   // ****************************************************************
   // power-on default from cell count
   // ****************************************************************
   // an unknown strap value falls back to the single-cell voltage, the
   // safest choice for an unknown pack
   always_comb begin
      unique case (cell_count_select_pin)
         3'h2: cell_default = CVS_DEF_2S;
         3'h3: cell_default = CVS_DEF_3S;
         3'h4: cell_default = CVS_DEF_4S;
         3'h5: cell_default = CVS_DEF_5S;
         default: cell_default = CVS_DEF_1S;
      endcase
   end

   // ****************************************************************
   // current clear causes
   // ****************************************************************
   assign cur_clear = (volt_hi_wr && volt_zero) || !battery_present ||
      !vbus_in_window || reg_reset_req || watchdog_event;

   // ****************************************************************
   // low-battery current clamp
   // ****************************************************************
   // no clamp for five cells: none is defined for that pack
   assign base_ma = 16'(st_reg.cur) * CVS_CUR_STEP_MA;

   always_comb begin
      clamp_on = 1'b0;
      clamp_ma = CVS_CLAMP_LOW_MA;
      if (batt_below_min_sys) begin
         if (cell_count_select_pin == 3'h1) begin
            clamp_on = 1'b1;
            clamp_ma = batt_below_3v ? CVS_CLAMP_LOW_MA
               : CVS_CLAMP_MID_MA;
         end else if ((cell_count_select_pin >= 3'h2) &&
               (cell_count_select_pin <= 3'h4)) begin
            clamp_on = 1'b1;
            clamp_ma = CVS_CLAMP_LOW_MA;
         end
      end
   end

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   always_comb begin
      st_next = st_reg;
      unique case (st_reg.state)
         // strap is sampled by a clocked step after reset release
         CVS_ST_LOAD: begin
            st_next.volt = cell_default;
            st_next.state = CVS_ST_RUN;
         end
         CVS_ST_RUN: begin
            if (req.wr && (req.addr == CVS_OFS_VOLT_LO)) begin
               st_next.volt_lo_stage = req.wdata;
            end
            if (req.wr && (req.addr == CVS_OFS_CUR_LO)) begin
               st_next.cur_lo_stage = req.wdata;
            end
            if (volt_hi_wr && volt_ok) begin
               st_next.volt = wr_volt_code;
            end
            if (cur_hi_wr && cur_ok) begin
               st_next.cur = wr_cur_code;
               // a nonzero current write starts charge if power is good in that cycle
               st_next.charging = charger_power_good &&
                  (wr_cur_code != 7'h00);
            end
            if (reg_reset_req) begin
               st_next.volt = cell_default;
               st_next.volt_lo_stage = 8'h00;
               st_next.cur_lo_stage = 8'h00;
            end
            if (cur_clear) begin
               st_next.cur = CVS_CUR_RESET;
               st_next.charging = 1'b0;
            end
            if (!charger_power_good) begin
               st_next.charging = 1'b0;
            end
         end
         default: st_next.state = CVS_ST_LOAD;
      endcase

      // effective current after clamping
      st_next.limit_ma = (clamp_on && (base_ma > clamp_ma)) ? clamp_ma
         : base_ma;

      // state flags, reserved bit 1 reads zero
      st_next.state_flags = {vbus_in_window,
         status_in.input_optimizer_done,
         status_in.in_assist_mode,
         status_in.in_input_voltage_regulation,
         status_in.in_input_current_regulation,
         status_in.in_fast_charge,
         1'b0,
         status_in.in_reverse_output};

      // read path, registered; unmapped offsets read zero
      if (req.rd) begin
         unique case (req.addr)
            CVS_OFS_CUR_LO:
               st_next.rdata = {st_reg.cur[1:0], 6'h00};
            CVS_OFS_CUR_HI:
               st_next.rdata = {3'h0, st_reg.cur[6:2]};
            CVS_OFS_VOLT_LO:
               st_next.rdata = {st_reg.volt[4:0], 3'h0};
            CVS_OFS_VOLT_HI:
               st_next.rdata = {1'b0, st_reg.volt[11:5]};
            CVS_OFS_FAULT:
               st_next.rdata = fault_flags;
            CVS_OFS_STATE:
               st_next.rdata = st_reg.state_flags;
            default:
               st_next.rdata = 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.state <= CVS_ST_LOAD;
         st_reg.volt <= 12'h000;
         st_reg.volt_lo_stage <= 8'h00;
         st_reg.cur <= CVS_CUR_RESET;
         st_reg.cur_lo_stage <= 8'h00;
         st_reg.charging <= 1'b0;
         st_reg.limit_ma <= 16'h0000;
         st_reg.state_flags <= CVS_STATUS_RESET;
         st_reg.rdata <= 8'h00;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign charge_voltage_setpoint = st_reg.volt;
   assign charge_current_setpoint = st_reg.cur;
   assign charge_current_limit_ma = st_reg.limit_ma;
   assign charge_enable = st_reg.charging;
   assign charger_state_register = st_reg.state_flags;
   assign reg_rdata = st_reg.rdata;
endmodule
`default_nettype wire

// ---- rtl/cvs_pkg.sv ----
// charge voltage setpoint and status block: shared constants and types
// assumes a byte-wide register port fed by the serial host interface
package cvs_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] CVS_OFS_CUR_LO = 8'h02;
   localparam logic [7:0] CVS_OFS_CUR_HI = 8'h03;
   localparam logic [7:0] CVS_OFS_VOLT_LO = 8'h04;
   localparam logic [7:0] CVS_OFS_VOLT_HI = 8'h05;
   localparam logic [7:0] CVS_OFS_FAULT = 8'h20;
   localparam logic [7:0] CVS_OFS_STATE = 8'h21;

   // ****************************************************************
   // field layout and reset values
   // ****************************************************************
   localparam int CVS_VOLT_HI_RSVD_BIT = 7;
   localparam int CVS_VOLT_LO_LSB = 3;
   localparam int CVS_CUR_LO_LSB = 6;
   localparam logic [7:0] CVS_CUR_HI_RSVD_MASK = 8'he0;
   localparam logic [7:0] CVS_FAULT_WR_MASK = 8'h18;
   localparam logic [7:0] CVS_STATUS_RESET = 8'h00;
   localparam logic [6:0] CVS_CUR_RESET = 7'h00;

   // ****************************************************************
   // voltage range and defaults, in mV and 8 mV codes
   // ****************************************************************
   localparam int CVS_STEP_MV = 8;
   localparam int CVS_MIN_MV = 1024;
   localparam int CVS_MAX_MV = 23000;
   localparam int CVS_CELL_MV = 4200;
   localparam logic [11:0] CVS_CODE_MIN = 12'(CVS_MIN_MV / CVS_STEP_MV);
   localparam logic [11:0] CVS_CODE_MAX = 12'(CVS_MAX_MV / CVS_STEP_MV);
   localparam logic [11:0] CVS_DEF_1S = 12'(1 * CVS_CELL_MV / CVS_STEP_MV);
   localparam logic [11:0] CVS_DEF_2S = 12'(2 * CVS_CELL_MV / CVS_STEP_MV);
   localparam logic [11:0] CVS_DEF_3S = 12'(3 * CVS_CELL_MV / CVS_STEP_MV);
   localparam logic [11:0] CVS_DEF_4S = 12'(4 * CVS_CELL_MV / CVS_STEP_MV);
   localparam logic [11:0] CVS_DEF_5S = 12'(5 * CVS_CELL_MV / CVS_STEP_MV);

   // ****************************************************************
   // charge current scaling and low-battery clamps, in mA
   // ****************************************************************
   localparam logic [15:0] CVS_CUR_STEP_MA = 16'd128;
   localparam logic [15:0] CVS_CLAMP_LOW_MA = 16'd384;
   localparam logic [15:0] CVS_CLAMP_MID_MA = 16'd2000;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      CVS_ST_LOAD = 2'b01,
      CVS_ST_RUN = 2'b10
   } cvs_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cvs_req_s;

   typedef struct packed {
      logic input_optimizer_done;
      logic in_assist_mode;
      logic in_input_voltage_regulation;
      logic in_input_current_regulation;
      logic in_fast_charge;
      logic in_reverse_output;
   } cvs_status_s;

   typedef struct packed {
      logic input_overvoltage_fault;
      logic battery_overcurrent_fault;
      logic input_overcurrent_fault;
      logic system_overvoltage_fault;
      logic system_undervoltage_fault;
      logic forced_converter_off;
      logic reverse_output_overvoltage_fault;
      logic reverse_output_undervoltage_fault;
   } cvs_fault_s;

endpackage

// ---- rtl/cvs_flag_cell.sv ----
// one status flag: either a live level or a sticky host-clearable bit
// assumes event_in is synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module cvs_flag_cell #(
   parameter bit WRITABLE = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // event and host write
   input wire logic event_in,
   input wire logic wr_en,
   input wire logic wr_val,
   // flag
   output logic flag
);
   typedef struct packed {
      logic flag;
   } cvs_cell_s;

   cvs_cell_s st_reg;
   cvs_cell_s st_next;

   // sticky bits: a new event beats a host clear in the same cycle
   always_comb begin
      st_next = st_reg;
      if (WRITABLE) begin
         st_next.flag = event_in | (wr_en ? wr_val : st_reg.flag);
      end else begin
         st_next.flag = event_in;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign flag = st_reg.flag;
endmodule
`default_nettype wire

// ---- sim/cvs_setpoint_monitor.sv ----
// assertion checker for the setpoint and status register block
// assumes it is bound to the block top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module cvs_setpoint_monitor
   import cvs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // byte register port
   input wire cvs_req_s req,
   input wire logic [7:0] reg_rdata,
   // configuration and events
   input wire logic [2:0] cell_count_select_pin,
   input wire logic battery_present,
   input wire logic vbus_in_window,
   input wire logic charger_power_good,
   input wire logic reg_reset_req,
   input wire logic watchdog_event,
   input wire logic batt_below_min_sys,
   input wire logic batt_below_3v,
   input wire cvs_status_s status_in,
   input wire cvs_fault_s fault_evt,
   // setpoints and status
   input wire logic [11:0] charge_voltage_setpoint,
   input wire logic [6:0] charge_current_setpoint,
   input wire logic [15:0] charge_current_limit_ma,
   input wire logic charge_enable,
   input wire logic [7:0] charger_state_register
);
   // ****************************************************************
   // helpers
   // ****************************************************************
   logic [1:0] age;
   logic [7:0] lo_q;
   logic vwr;
   logic [11:0] wcode;
   logic [15:0] lim;
   // age skips the load cycle; lo_q mirrors the staged low byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         age <= 2'h0;
         lo_q <= 8'h00;
      end else begin
         age <= (age == 2'h3) ? age : age + 2'h1;
         if (reg_reset_req) lo_q <= 8'h00;
         else if (req.wr && req.addr == CVS_OFS_VOLT_LO && age != 2'h0)
            lo_q <= req.wdata;
      end
   end
   // clamp expectation; only straps 1 to 4 clamp, any other never does
   always_comb begin
      lim = 16'hffff;
      if (batt_below_min_sys && cell_count_select_pin inside {[2:4]})
         lim = CVS_CLAMP_LOW_MA;
      else if (batt_below_min_sys && cell_count_select_pin == 3'h1)
         lim = batt_below_3v ? CVS_CLAMP_LOW_MA : CVS_CLAMP_MID_MA;
   end
   assign vwr = req.wr && req.addr == CVS_OFS_VOLT_HI && age != 2'h0;
   assign wcode = {req.wdata[6:0], lo_q[7:3]};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ****************************************************************
   // properties
   // ****************************************************************
   property p_range;
      age != 2'h0 |-> charge_voltage_setpoint inside {[128:2875]};
   endproperty
   a_range: assert property (p_range) else $error("voltage out of range");
   property p_def;
      age == 2'h1 |-> charge_voltage_setpoint == 12'd525 *
         ((cell_count_select_pin inside {[1:5]}) ? cell_count_select_pin : 1);
   endproperty
   a_def: assert property (p_def) else $error("bad default voltage");
   property p_vwrite;
      vwr && !req.wdata[7] && wcode inside {[128:2875]} && !reg_reset_req
         |=> charge_voltage_setpoint == $past(wcode);
   endproperty
   a_vwrite: assert property (p_vwrite) else $error("write not applied");
   property p_vbad;
      vwr && (req.wdata[7] || !(wcode inside {[128:2875]})) && !reg_reset_req
         |=> $stable(charge_voltage_setpoint);
   endproperty
   a_vbad: assert property (p_vbad) else $error("bad write applied");
   property p_vhold;
      age > 2'h1 && $changed(charge_voltage_setpoint) |->
         $past(vwr) || $past(reg_reset_req) || $past(reg_reset_req, 2);
   endproperty
   a_vhold: assert property (p_vhold) else $error("stray change");
   property p_zero;
      vwr && !req.wdata[7] && wcode == 12'h000 |=> charge_current_setpoint == 0;
   endproperty
   a_zero: assert property (p_zero) else $error("zero kept current");
   property p_clear;
      age != 2'h0 && (!battery_present || !vbus_in_window || watchdog_event ||
         reg_reset_req) |=> charge_current_setpoint == 0 && !charge_enable;
   endproperty
   a_clear: assert property (p_clear) else $error("current kept");
   property p_clamp;
      age > 2'h1 && $stable({charge_current_setpoint, batt_below_min_sys,
         batt_below_3v}) |-> charge_current_limit_ma ==
         (({9'h0, charge_current_setpoint} << 7) < lim ?
         {9'h0, charge_current_setpoint} << 7 : lim);
   endproperty
   a_clamp: assert property (p_clamp) else $error("bad limit");
   property p_state;
      age > 2'h1 && $stable({vbus_in_window, status_in}) |->
         charger_state_register == {vbus_in_window, status_in[5:1], 1'b0,
         status_in[0]};
   endproperty
   a_state: assert property (p_state) else $error("bad state byte");
   property p_fault;
      age > 2'h1 && req.rd && req.addr == CVS_OFS_FAULT && $stable(fault_evt)
         |=> (reg_rdata & 8'he7) == ($past(fault_evt) & 8'he7);
   endproperty
   a_fault: assert property (p_fault) else $error("bad fault byte");
   c_vwr: cover property (vwr && wcode inside {[128:2875]});
   c_zero: cover property (vwr && wcode == 12'h000);
   c_mid: cover property (batt_below_min_sys && !batt_below_3v);
endmodule
bind cvs_setpoint_regs cvs_setpoint_monitor u_mon (.clk(clk), .rst_n(rst_n),
   .req(req), .reg_rdata(reg_rdata),
   .cell_count_select_pin(cell_count_select_pin),
   .battery_present(battery_present), .vbus_in_window(vbus_in_window),
   .charger_power_good(charger_power_good), .reg_reset_req(reg_reset_req),
   .watchdog_event(watchdog_event), .batt_below_min_sys(batt_below_min_sys),
   .batt_below_3v(batt_below_3v), .status_in(status_in),
   .fault_evt(fault_evt), .charge_voltage_setpoint(charge_voltage_setpoint),
   .charge_current_setpoint(charge_current_setpoint),
   .charge_current_limit_ma(charge_current_limit_ma),
   .charge_enable(charge_enable),
   .charger_state_register(charger_state_register));
`default_nettype wire

// ---- sim/cvs_host_model.sv ----
// host model: byte writes, low-then-high word writes and byte reads
// assumes one strobe per edge and read data the cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module cvs_host_model
   import cvs_pkg::*;
(
   // clock
   input wire logic clk,
   // byte register port
   output var cvs_req_s req,
   input wire logic [7:0] reg_rdata
);
   // ****************************************************************
   // transfers
   // ****************************************************************
   initial req = '0;
   // released lines show the inverse, never a stale match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // word sent as one unit, low byte first, high byte bit 7 as given
   task automatic wr_word(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, v[7:0]};
      @(posedge clk);
      req <= '{1'b1, 1'b0, a + 8'h01, v[15:8]};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, ~v[15:8]};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, 8'hff};
      #1 d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ---- sim/tb_charge_voltage_setpoint_and_status.sv ----
// self-checking bench for the setpoint and status register block
// assumes the host model and the bound monitor are compiled with it
`timescale 1ns/100ps
`default_nettype none
module tb_charge_voltage_setpoint_and_status
   import cvs_pkg::*;
;
   logic clk, rst_n, battery_present, vbus_in_window, charger_power_good;
   logic reg_reset_req, watchdog_event, batt_below_min_sys, batt_below_3v;
   logic [2:0] cell_count_select_pin;
   cvs_req_s req;
   cvs_status_s status_in;
   cvs_fault_s fault_evt;
   logic [7:0] reg_rdata, charger_state_register;
   logic [11:0] charge_voltage_setpoint;
   logic [6:0] charge_current_setpoint;
   logic [15:0] charge_current_limit_ma;
   logic charge_enable;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [11:0] tbl [6] = '{12'd128, 12'd2875, 12'd127, 12'd2876, 12'hfff,
      12'h000};
   cvs_setpoint_regs dut (.clk(clk), .rst_n(rst_n), .req(req),
      .reg_rdata(reg_rdata), .cell_count_select_pin(cell_count_select_pin),
      .battery_present(battery_present), .vbus_in_window(vbus_in_window),
      .charger_power_good(charger_power_good), .reg_reset_req(reg_reset_req),
      .watchdog_event(watchdog_event), .batt_below_min_sys(batt_below_min_sys),
      .batt_below_3v(batt_below_3v), .status_in(status_in),
      .fault_evt(fault_evt), .charge_voltage_setpoint(charge_voltage_setpoint),
      .charge_current_setpoint(charge_current_setpoint),
      .charge_current_limit_ma(charge_current_limit_ma),
      .charge_enable(charge_enable),
      .charger_state_register(charger_state_register));
   cvs_host_model host (.clk(clk), .req(req), .reg_rdata(reg_rdata));
   // ****************************************************************
   // clock, watchdog on the run, helpers
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // a hang costs a mismatch rather than an endless run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // reset with a new cell count, return at the first legal request edge
   task automatic do_reset(input logic [2:0] n);
      @(posedge clk);
      cell_count_select_pin <= n;
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      logic [7:0] d, st, f, sticky;
      logic [11:0] ev, code;
      logic bad;
      int e;
      rst_n = 1'b0;
      {battery_present, vbus_in_window, charger_power_good} = 3'b111;
      {reg_reset_req, watchdog_event, batt_below_min_sys, batt_below_3v} = 4'h0;
      cell_count_select_pin = 3'h1;
      status_in = '0;
      fault_evt = '0;
      e = $urandom(32'h3b1c);
      // defaults and clamps per cell count, pin value 0 takes the one-cell default but never clamps
      for (int c = 0; c < 6; c++) begin
         do_reset(3'(c));
         ev = (c >= 1) ? 12'(c * 525) : 12'd525;
         chk(charge_voltage_setpoint, ev);
         host.rd(CVS_OFS_VOLT_HI, d);
         chk(d, {1'b0, ev[11:5]});
         host.wr_word(CVS_OFS_CUR_LO, 16'h1fc0);
         #1 chk({charge_enable, charge_current_setpoint}, 8'hff);
         for (int k = 0; k < 4; k++) begin
            @(posedge clk) {batt_below_min_sys, batt_below_3v} <= 2'(k);
            @(posedge clk);
            e = !k[1] ? 16256 : (c >= 2 && c <= 4) ? 384 : (c != 1) ? 16256 :
               k[0] ? 384 : 2000;
            #1 chk(charge_current_limit_ma, 16'(e));
         end
      end
      @(posedge clk) {batt_below_min_sys, batt_below_3v} <= 2'b00;
      // range edges, zero, then random codes with junk low bits, the first with bad bit 7
      for (int i = 0; i < 24; i++) begin
         code = (i < 6) ? tbl[i] : 12'($urandom_range(2875, 128));
         bad = (i == 6);
         host.wr(CVS_OFS_VOLT_LO, {code[4:0], 3'($urandom)});
         #1 chk(charge_voltage_setpoint, ev);
         host.wr(CVS_OFS_VOLT_HI, {bad, code[11:5]});
         if (!bad && code >= 12'd128 && code <= 12'd2875) ev = code;
         #1 chk(charge_voltage_setpoint, ev);
         if (code == 12'h000) chk(charge_current_setpoint, 7'h00);
         host.rd(CVS_OFS_VOLT_LO, d);
         chk(d, {ev[4:0], 3'b000});
      end
      // the four input causes that drop the current setpoint, then power good loss, which only stops charge
      for (int k = 0; k < 5; k++) begin
         host.wr_word(CVS_OFS_CUR_LO, 16'h1fc0);
         #1 chk(charge_current_setpoint, 7'h7f);
         @(posedge clk);
         case (k)
            0: battery_present <= 1'b0;
            1: vbus_in_window <= 1'b0;
            2: watchdog_event <= 1'b1;
            3: reg_reset_req <= 1'b1;
            default: charger_power_good <= 1'b0;
         endcase
         @(posedge clk) {battery_present, vbus_in_window} <= 2'b11;
         {watchdog_event, reg_reset_req, charger_power_good} <= 3'b001;
         d = (k == 4) ? 8'h7f : 8'h00;
         #1 chk({charge_enable, charge_current_setpoint}, d);
      end
      // status bytes: live flags, sticky writable faults, read-only high
      sticky = 8'h00;
      for (int k = 0; k < 12; k++) begin
         st = 8'($urandom);
         f = 8'($urandom);
         if (!k[0]) f[4:3] = 2'b00;
         @(posedge clk) status_in <= st[5:0];
         fault_evt <= f;
         vbus_in_window <= st[7];
         if (!k[0]) begin
            host.wr(CVS_OFS_FAULT, st);
            host.wr(CVS_OFS_STATE, f);
            sticky = st & 8'h18;
         end else begin
            sticky = sticky | (f & 8'h18);
         end
         host.rd(CVS_OFS_STATE, d);
         chk(d, {st[7], st[5:1], 1'b0, st[0]});
         chk(charger_state_register, {st[7], st[5:1], 1'b0, st[0]});
         host.rd(CVS_OFS_FAULT, d);
         chk(d, (f & 8'he7) | sticky);
      end
      host.rd(8'h40, d);
      chk(d, 8'h00);
      finish_test();
   end
endmodule
`default_nettype wire
